// ==== mpfc_assertions.sv ====
// mpfc_assertions: port-level checks for mpfc_top, bound below.
// assumes the pause frame and management counts are at least 8 cycles.
`default_nettype none
module mpfc_assertions #(
    parameter int QUANTUM_CYCLES = mpfc_pkg::QUANTUM_CYC
) (
    input wire logic                  pclk,
    input wire logic                  presetn,
    input wire logic                  psel,
    input wire logic                  penable,
    input wire logic                  pwrite,
    input wire logic [11:0]           paddr,
    input wire logic [31:0]           pwdata,
    input wire logic [31:0]           prdata,
    input wire logic                  pready,
    input wire logic                  pslverr,
    input wire logic                  rx_pause_valid,
    input wire logic [15:0]           rx_pause_quanta,
    input wire mpfc_pkg::mpfc_pause_t tx_pause_req,
    input wire logic                  tx_stall,
    input wire logic                  mgmt_start
);
    logic        honor_q;
    logic [15:0] fcq_q;
    int          left_q;
    wire logic   fc_wr = psel && penable && pready && pwrite && paddr == mpfc_pkg::FLOW_CTRL_ADDR;
    // stall budget mirrors the honour bit one cycle late, so apb traffic is excluded
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            honor_q <= mpfc_pkg::FC_HONOR_RST;
            fcq_q   <= mpfc_pkg::FC_QUANTA_RST;
            left_q  <= 0;
        end else begin
            if (fc_wr) begin
                honor_q <= pwdata[1];
                fcq_q   <= pwdata[31:16];
            end
            if (fc_wr && !pwdata[1]) begin
                left_q <= 0;
            end else if (rx_pause_valid && honor_q && !psel) begin
                left_q <= QUANTUM_CYCLES * int'(rx_pause_quanta);
            end else if (left_q != 0) begin
                left_q <= left_q - 1;
            end
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_access;
        psel && !penable ##1 psel && penable && !pready;
    endsequence
    a_ready_after_access: assert property (s_access |=> pready)
        else $error("pready missing after access cycle");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_slverr_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr outside pready");
    a_rdata_idle_zero: assert property (!pready |-> prdata == 32'h0000_0000)
        else $error("prdata not zero while idle");
    a_pause_frame_spacing: assert property (tx_pause_req.valid |=> !tx_pause_req.valid [*8])
        else $error("pause request before frame end");
    a_pause_quanta_value: assert property (tx_pause_req.valid |-> tx_pause_req.quanta == fcq_q)
        else $error("pause frame quanta wrong");
    a_stall_on_pause: assert property (
        rx_pause_valid && rx_pause_quanta != 16'h0000 && honor_q && !psel |=> tx_stall)
        else $error("no stall after pause frame");
    a_stall_length_match: assert property (!psel && !$past(psel) |-> tx_stall == (left_q != 0))
        else $error("stall length wrong");
    a_mgmt_start_spacing: assert property (mgmt_start |=> !mgmt_start [*8])
        else $error("management start while busy");
endmodule : mpfc_assertions

bind mpfc_top mpfc_assertions #(.QUANTUM_CYCLES(QUANTUM_CYCLES)) i_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_pause_valid(rx_pause_valid), .rx_pause_quanta(rx_pause_quanta),
    .tx_pause_req(tx_pause_req), .tx_stall(tx_stall), .mgmt_start(mgmt_start));
`default_nettype wire

// ==== mpfc_partner.sv ====
// mpfc_partner: remote ethernet node; sends pause frames and tx frame events
// on command, logs pause frames from the mac and stalled transmitter cycles.
`default_nettype none
module mpfc_partner (
    input  wire logic                  pclk,
    input  wire mpfc_pkg::mpfc_pause_t tx_pause_req,
    input  wire logic                  tx_stall,
    output logic                       rx_pause_valid,
    output logic [15:0]                rx_pause_quanta,
    output logic                       tx_frame_done,
    output logic [15:0]                tx_frame_len
);
    timeunit 1ns;
    timeprecision 1ps;
    int          n_pause = 0;
    int          stall_cyc = 0;
    logic [15:0] last_quanta = 16'h0000;
    initial begin
        rx_pause_valid  = 1'b0;
        tx_frame_done   = 1'b0;
        rx_pause_quanta = 16'hFFFF;
        tx_frame_len    = 16'hFFFF;
    end
    always @(posedge pclk) begin
        if (tx_pause_req.valid === 1'b1) begin
            n_pause++;
            last_quanta = tx_pause_req.quanta;
        end
        if (tx_stall === 1'b1) begin
            stall_cyc++;
        end
    end
    // idle data lines show the inverse so a stale value never looks valid
    task automatic send(input logic pause, input logic [15:0] val);
        rx_pause_valid  <= pause;
        tx_frame_done   <= !pause;
        rx_pause_quanta <= val;
        tx_frame_len    <= val;
        @(posedge pclk);
        rx_pause_valid  <= 1'b0;
        tx_frame_done   <= 1'b0;
        rx_pause_quanta <= ~val;
        tx_frame_len    <= ~val;
        @(posedge pclk);
    endtask : send
endmodule : mpfc_partner
`default_nettype wire

// ==== mpfc_pkg.sv ====
// mpfc_pkg: register map, field layout, reset values and timing for the
// pause flow control block. assumes a 32-bit apb bus and a 125 mhz pclk.
`default_nettype none

package mpfc_pkg;

    // register byte addresses
    localparam logic [11:0] MGMT_DATA_ADDR    = 12'h018;
    localparam logic [11:0] FLOW_CTRL_ADDR    = 12'h01C;
    localparam logic [11:0] CNT_CTRL_ADDR     = 12'h100;
    localparam logic [11:0] RSVD_INIT_A_ADDR  = 12'h10C;
    localparam logic [11:0] RSVD_INIT_B_ADDR  = 12'h110;
    localparam logic [11:0] MGMT_CMD_ADDR     = 12'h014;
    localparam logic [11:0] LONG_CNT_ADDR     = 12'h120;

    // flow control word fields
    localparam int          FC_BUSY_BIT       = 0;
    localparam int          FC_HONOR_BIT      = 1;
    localparam int          FC_QUANTA_LSB     = 16;
    localparam logic [15:0] FC_QUANTA_RST     = 16'h0050;
    localparam logic        FC_HONOR_RST      = 1'h1;

    // counter control word fields
    localparam int          CC_RSVD1_BIT      = 1;
    localparam int          CC_MAXLEN_LSB     = 3;
    localparam logic [10:0] CC_MAXLEN_RST     = 11'h5EE;
    localparam logic        CC_RSVD1_RST      = 1'h1;

    // management command word fields
    localparam int          MG_BUSY_BIT       = 0;
    localparam int          MG_WRITE_BIT      = 1;

    // one pause quantum is 512 bit times; at 100 mb/s that is 5120 ns
    localparam int          QUANTUM_NS        = 5120;
    localparam int          CLK_NS            = 8;
    localparam int          QUANTUM_CYC       = QUANTUM_NS / CLK_NS;
    // pause frame is 64 bytes plus preamble and gap: 84 byte times
    localparam int          PFRAME_NS         = 6720;
    localparam int          PFRAME_CYC        = (PFRAME_NS + CLK_NS - 1) / CLK_NS;
    // one mdio instruction: 64 mdc bits at 2.5 mhz
    localparam int          MGMT_NS           = 25600;
    localparam int          MGMT_CYC          = (MGMT_NS + CLK_NS - 1) / CLK_NS;

    typedef enum logic [1:0] {
        MPFC_TX_IDLE  = 2'b00,
        MPFC_TX_SEND  = 2'b01,
        MPFC_TX_PAUSE = 2'b10
    } mpfc_tx_t;

    typedef struct packed {
        logic        valid;
        logic [15:0] quanta;
    } mpfc_pause_t;

endpackage : mpfc_pkg

`default_nettype wire

// ==== mpfc_top.sv ====
// mpfc_top: pause flow control, management command word and long frame
// classification for an ethernet mac, as an apb slave.
// assumes the mac core pulses the tx/rx event inputs synchronous to pclk.
// assumes the apb master waits for pready; every access gets one wait state.
// the mdio shifter and the pause frame sender sit outside; only their timing is kept.
// Operation
// - The 16-bit management data field holds write data or read-back data.
// - Every sent pause frame carries the pause quanta from bits 31:16.
// - With honour enabled, a received pause frame stalls the transmitter.
// - The send busy bit stays one while the pause frame is sent.
// - The device clears the send busy bit when the pause frame ends.
// - Bits 13:3 of the counter control word give the maximum frame length.
// - Each sent frame longer than that maximum counts as a long frame.
// - The management busy flag is one while an instruction runs.
//
// Register access over APB was left to the implementer.
`default_nettype none

module mpfc_top #(
    parameter int QUANTUM_CYCLES = mpfc_pkg::QUANTUM_CYC,
    parameter int PFRAME_CYCLES  = mpfc_pkg::PFRAME_CYC,
    parameter int MGMT_CYCLES    = mpfc_pkg::MGMT_CYC
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        rx_pause_valid,
    input  wire logic [15:0] rx_pause_quanta,
    input  wire logic        tx_frame_done,
    input  wire logic [15:0] tx_frame_len,
    input  wire logic [15:0] mgmt_rd_data,
    output mpfc_pkg::mpfc_pause_t tx_pause_req,
    output logic             tx_stall,
    output logic             mgmt_start,
    output logic             mgmt_write_select,
    output logic [15:0]      mgmt_data_out
);

    // whole block state in one register so reset and update stay in one place
    typedef struct packed {
        logic [31:0]        rdata;
        logic               ready;
        logic               slverr;
        logic [15:0]        quanta;
        logic               honor;
        logic               busy;
        mpfc_pkg::mpfc_tx_t tx_st;
        logic [15:0]        tx_cnt;
        logic [15:0]        pause_left;
        logic [15:0]        quantum_cnt;
        logic [10:0]        max_len;
        logic               cc_rsvd1;
        logic [31:0]        rsvd_a;
        logic [31:0]        rsvd_b;
        logic [31:0]        long_cnt;
        logic [15:0]        mgmt_data;
        logic               mgmt_busy;
        logic               mgmt_wsel;
        logic [15:0]        mgmt_cnt;
        logic               mgmt_start;
        mpfc_pkg::mpfc_pause_t pause_out;
        logic               stall;
    } mpfc_state_t;

    mpfc_state_t s_q;
    mpfc_state_t s_d;

    // last counts, cut to the counter width on purpose
    localparam logic [15:0] PF_LAST = 16'(PFRAME_CYCLES - 1);
    localparam logic [15:0] Q_LAST  = 16'(QUANTUM_CYCLES - 1);
    localparam logic [15:0] MG_LAST = 16'(MGMT_CYCLES - 1);

    // true for any address that answers with a register;
    // used both for the error response and to gate every store
    function automatic logic mpfc_mapped(input logic [11:0] a);
        mpfc_mapped = (a == mpfc_pkg::FLOW_CTRL_ADDR) ||
                      (a == mpfc_pkg::CNT_CTRL_ADDR) ||
                      (a == mpfc_pkg::RSVD_INIT_A_ADDR) ||
                      (a == mpfc_pkg::RSVD_INIT_B_ADDR) ||
                      (a == mpfc_pkg::MGMT_CMD_ADDR) ||
                      (a == mpfc_pkg::MGMT_DATA_ADDR) ||
                      (a == mpfc_pkg::LONG_CNT_ADDR);
    endfunction : mpfc_mapped

    logic        acc;
    logic        wr;
    logic [31:0] rd;

    always_comb begin
        s_d         = s_q;
        // registered answer costs one wait state; the !ready term ends the access
        acc         = psel && penable && !s_q.ready;
        // an errored write stores nothing
        wr          = acc && pwrite && mpfc_mapped(paddr);
        s_d.ready   = acc;
        s_d.slverr  = acc && !mpfc_mapped(paddr);
        // pulses default low and are raised below for one cycle
        s_d.mgmt_start = 1'b0;
        s_d.pause_out.valid = 1'b0;

        rd = 32'h0000_0000;
        case (paddr)
            mpfc_pkg::FLOW_CTRL_ADDR: begin
                rd[mpfc_pkg::FC_QUANTA_LSB +: 16] = s_q.quanta;
                rd[mpfc_pkg::FC_HONOR_BIT] = s_q.honor;
                rd[mpfc_pkg::FC_BUSY_BIT]  = s_q.busy;
            end
            mpfc_pkg::CNT_CTRL_ADDR: begin
                rd[mpfc_pkg::CC_MAXLEN_LSB +: 11] = s_q.max_len;
                rd[mpfc_pkg::CC_RSVD1_BIT] = s_q.cc_rsvd1;
            end
            mpfc_pkg::RSVD_INIT_A_ADDR: begin
                rd = s_q.rsvd_a;
            end
            mpfc_pkg::RSVD_INIT_B_ADDR: begin
                rd = s_q.rsvd_b;
            end
            mpfc_pkg::MGMT_CMD_ADDR: begin
                rd[mpfc_pkg::MG_WRITE_BIT] = s_q.mgmt_wsel;
                rd[mpfc_pkg::MG_BUSY_BIT]  = s_q.mgmt_busy;
            end
            mpfc_pkg::MGMT_DATA_ADDR: begin
                rd[15:0] = s_q.mgmt_data;
            end
            mpfc_pkg::LONG_CNT_ADDR: begin
                rd = s_q.long_cnt;
            end
            default: begin
                // unmapped reads return zero alongside the error
                rd = 32'h0000_0000;
            end
        endcase
        // data only while the answer stands, so a stale word never sits on the bus
        s_d.rdata = (acc && !pwrite) ? rd : 32'h0000_0000;

        if (wr) begin
            case (paddr)
                mpfc_pkg::FLOW_CTRL_ADDR: begin
                    s_d.quanta = pwdata[mpfc_pkg::FC_QUANTA_LSB +: 16];
                    s_d.honor  = pwdata[mpfc_pkg::FC_HONOR_BIT];
                    // host write of one requests a frame
                    if (pwdata[mpfc_pkg::FC_BUSY_BIT]) begin
                        s_d.busy = 1'b1;
                    end
                end
                mpfc_pkg::CNT_CTRL_ADDR: begin
                    s_d.max_len  = pwdata[mpfc_pkg::CC_MAXLEN_LSB +: 11];
                    s_d.cc_rsvd1 = pwdata[mpfc_pkg::CC_RSVD1_BIT];
                end
                mpfc_pkg::RSVD_INIT_A_ADDR: begin
                    s_d.rsvd_a = pwdata;
                end
                mpfc_pkg::RSVD_INIT_B_ADDR: begin
                    s_d.rsvd_b = pwdata;
                end
                mpfc_pkg::MGMT_CMD_ADDR: begin
                    // a command while busy is ignored so the running one is not torn
                    if (!s_q.mgmt_busy) begin
                        s_d.mgmt_wsel  = pwdata[mpfc_pkg::MG_WRITE_BIT];
                        s_d.mgmt_busy  = 1'b1;
                        s_d.mgmt_start = 1'b1;
                        s_d.mgmt_cnt   = 16'h0000;
                    end
                end
                mpfc_pkg::MGMT_DATA_ADDR: begin
                    s_d.mgmt_data = pwdata[15:0];
                end
                default: begin
                    // the long frame counter is read-only
                end
            endcase
        end

        // busy until the instruction time has run out
        if (s_q.mgmt_busy) begin
            if (s_q.mgmt_cnt == MG_LAST) begin
                s_d.mgmt_busy = 1'b0;
                // a read returns its data into the data field
                if (!s_q.mgmt_wsel) begin
                    s_d.mgmt_data = mgmt_rd_data;
                end
            end else begin
                s_d.mgmt_cnt = s_q.mgmt_cnt + 16'h0001;
            end
        end

        // received pause honoured only when enabled
        if (rx_pause_valid && s_q.honor) begin
            // a new pause frame reloads the count rather than adding to it
            s_d.pause_left  = rx_pause_quanta;
            s_d.quantum_cnt = 16'h0000;
        end else if (s_q.pause_left != 16'h0000) begin
            // one quantum of 512 bit times per decrement
            if (s_q.quantum_cnt == Q_LAST) begin
                s_d.quantum_cnt = 16'h0000;
                s_d.pause_left  = s_q.pause_left - 16'h0001;
            end else begin
                s_d.quantum_cnt = s_q.quantum_cnt + 16'h0001;
            end
        end
        // dropping the enable releases a stall already running
        if (!s_d.honor) begin
            s_d.pause_left = 16'h0000;
        end
        // taken from the next count so the stall rises the cycle after the pulse
        s_d.stall = (s_d.pause_left != 16'h0000);

        // pause frames are control frames and go out even while stalled
        case (s_q.tx_st)
            mpfc_pkg::MPFC_TX_IDLE: begin
                if (s_q.busy) begin
                    // quanta placed in the outgoing frame
                    s_d.pause_out.valid  = 1'b1;
                    s_d.pause_out.quanta = s_q.quanta;
                    s_d.tx_cnt = 16'h0000;
                    s_d.tx_st  = mpfc_pkg::MPFC_TX_SEND;
                end
            end
            mpfc_pkg::MPFC_TX_SEND: begin
                // busy held through the frame
                // re-asserted so no host write can end the frame early
                s_d.busy = 1'b1;
                if (s_q.tx_cnt == PF_LAST) begin
                    s_d.busy  = 1'b0;
                    s_d.tx_st = mpfc_pkg::MPFC_TX_IDLE;
                end else begin
                    s_d.tx_cnt = s_q.tx_cnt + 16'h0001;
                end
            end
            default: begin
                // an unused code falls back to idle
                s_d.tx_st = mpfc_pkg::MPFC_TX_IDLE;
            end
        endcase

        // long frame count, rolls over
        // a frame exactly at the limit is not long
        if (tx_frame_done && (tx_frame_len > {5'h00, s_q.max_len})) begin
            s_d.long_cnt = s_q.long_cnt + 32'h0000_0001;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            // documented defaults for the visible fields, idle for the rest
            s_q.rdata       <= 32'h0000_0000;
            s_q.ready       <= 1'b0;
            s_q.slverr      <= 1'b0;
            s_q.quanta      <= mpfc_pkg::FC_QUANTA_RST;
            s_q.honor       <= mpfc_pkg::FC_HONOR_RST;
            s_q.busy        <= 1'b0;
            s_q.tx_st       <= mpfc_pkg::MPFC_TX_IDLE;
            s_q.tx_cnt      <= 16'h0000;
            s_q.pause_left  <= 16'h0000;
            s_q.quantum_cnt <= 16'h0000;
            s_q.max_len     <= mpfc_pkg::CC_MAXLEN_RST;
            s_q.cc_rsvd1    <= mpfc_pkg::CC_RSVD1_RST;
            s_q.rsvd_a      <= 32'h0000_0000;
            s_q.rsvd_b      <= 32'h0000_0000;
            s_q.long_cnt    <= 32'h0000_0000;
            s_q.mgmt_data   <= 16'h0000;
            s_q.mgmt_busy   <= 1'b0;
            s_q.mgmt_wsel   <= 1'b0;
            s_q.mgmt_cnt    <= 16'h0000;
            s_q.mgmt_start  <= 1'b0;
            s_q.pause_out   <= '0;
            s_q.stall       <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    // every output comes straight from the state register
    assign prdata            = s_q.rdata;
    assign pready            = s_q.ready;
    assign pslverr           = s_q.slverr;
    assign tx_pause_req      = s_q.pause_out;
    assign tx_stall          = s_q.stall;
    assign mgmt_start        = s_q.mgmt_start;
    assign mgmt_write_select = s_q.mgmt_wsel;
    assign mgmt_data_out     = s_q.mgmt_data;

endmodule : mpfc_top

`default_nettype wire

// ==== tb_mac_pause_flow_control.sv ====
// tb_mac_pause_flow_control: self-checking bench for mpfc_top and the node
// model; short count parameters keep the run under three hundred cycles.
`default_nettype none
module tb_mac_pause_flow_control;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int QC = 4;
    logic                  pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic                  rxv, txd, mst, mws, stall;
    logic [11:0]           paddr;
    logic [31:0]           pwdata, prdata, rd, d;
    logic [15:0]           rxq, txl, mrd, mdo, q;
    mpfc_pkg::mpfc_pause_t preq;
    int                    err_count, n_checks, cyc, longs, maxlen, l, n_start;
    mpfc_top #(.QUANTUM_CYCLES(QC), .PFRAME_CYCLES(8), .MGMT_CYCLES(8)) i_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .rx_pause_valid(rxv), .rx_pause_quanta(rxq), .tx_frame_done(txd),
        .tx_frame_len(txl), .mgmt_rd_data(mrd), .tx_pause_req(preq), .tx_stall(stall),
        .mgmt_start(mst), .mgmt_write_select(mws), .mgmt_data_out(mdo));
    mpfc_partner i_nd (.pclk(pclk), .tx_pause_req(preq), .tx_stall(stall),
        .rx_pause_valid(rxv), .rx_pause_quanta(rxq), .tx_frame_done(txd), .tx_frame_len(txl));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        chk({31'h0, pready}, 32'h1);
        psel <= 1'b0; penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic poll(input logic [11:0] a);
        int n;
        n = 0;
        do apb(1'b0, a, 32'h0); while (rd[0] !== 1'b0 && ++n < 40);
    endtask : poll
    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : results
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cyc++;
        if (mst === 1'b1) n_start++;
        if (cyc == 20000) begin
            err_count++;
            results();
        end
    end
    initial begin
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000;
        pwdata = 32'h0; mrd = 16'h0; err_count = 0; n_checks = 0; cyc = 0; n_start = 0;
        void'($urandom(32'hD048C519));
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, mpfc_pkg::FLOW_CTRL_ADDR, 32'h0); chk(rd, 32'h0050_0002);
        apb(1'b0, mpfc_pkg::CNT_CTRL_ADDR, 32'h0); chk(rd, 32'h0000_2F72);
        apb(1'b0, 12'h200, 32'h0); chk({rd[30:0], err}, 32'h1);
        $display("test reset done");
        maxlen = 64 + $urandom_range(0, 255);
        apb(1'b1, mpfc_pkg::CNT_CTRL_ADDR, 32'(maxlen << 3) | 32'h2);
        apb(1'b0, mpfc_pkg::CNT_CTRL_ADDR, 32'h0); chk(rd, 32'(maxlen << 3) | 32'h2);
        apb(1'b1, mpfc_pkg::RSVD_INIT_A_ADDR, 32'hFFFF_FFFF);
        apb(1'b0, mpfc_pkg::RSVD_INIT_A_ADDR, 32'h0); chk(rd, 32'hFFFF_FFFF);
        longs = 0;
        for (int i = 0; i < 8; i++) begin
            l = (i < 3) ? maxlen - 1 + i : $urandom_range(0, 600);
            longs += (l > maxlen);
            i_nd.send(1'b0, 16'(l));
        end
        apb(1'b0, mpfc_pkg::LONG_CNT_ADDR, 32'h0); chk(rd, 32'(longs));
        $display("test long frames done");
        poll(mpfc_pkg::FLOW_CTRL_ADDR); chk({31'h0, rd[0]}, 32'h0);
        q = 16'($urandom);
        apb(1'b1, mpfc_pkg::FLOW_CTRL_ADDR, {q, 16'h0003});
        apb(1'b0, mpfc_pkg::FLOW_CTRL_ADDR, 32'h0); chk(rd, {q, 16'h0003});
        poll(mpfc_pkg::FLOW_CTRL_ADDR); chk(rd, {q, 16'h0002});
        chk(32'(i_nd.n_pause), 32'h1); chk({16'h0, i_nd.last_quanta}, {16'h0, q});
        i_nd.stall_cyc = 0;
        i_nd.send(1'b1, 16'h0003);
        repeat (20) @(posedge pclk);
        chk(32'(i_nd.stall_cyc), 32'(3 * QC));
        apb(1'b1, mpfc_pkg::FLOW_CTRL_ADDR, {q, 16'h0000});
        i_nd.send(1'b1, 16'h0005);
        repeat (30) @(posedge pclk);
        chk(32'(i_nd.stall_cyc), 32'(3 * QC));
        $display("test pause done");
        for (int w = 0; w < 2; w++) begin
            d = $urandom;
            mrd <= d[31:16];
            apb(1'b1, mpfc_pkg::MGMT_DATA_ADDR, {16'h0, d[15:0]});
            apb(1'b1, mpfc_pkg::MGMT_CMD_ADDR, 32'(w << 1));
            chk({31'h0, mws}, 32'(w));
            poll(mpfc_pkg::MGMT_CMD_ADDR); chk(rd, 32'(w << 1));
            apb(1'b0, mpfc_pkg::MGMT_DATA_ADDR, 32'h0);
            chk(rd, {16'h0, w ? d[15:0] : d[31:16]});
        end
        chk({16'h0, mdo}, {16'h0, d[15:0]});
        chk(32'(n_start), 32'h2);
        $display("test management done");
        results();
    end
endmodule : tb_mac_pause_flow_control
`default_nettype wire
